/* verilog/pcsm_mux.sv */
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module pcsm_mux (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port C pads
    input wire logic [10:0] pad_in,
    output logic [10:0] pad_out,
    output logic [10:0] pad_oe,
    // Low pins: decoder one / timer group b side
    output logic [3:0] quad_decoder_one_in,
    input wire logic [3:0] timer_group_b_out,
    input wire logic [3:0] timer_output_enable,
    // Low pins: serial peripheral one side
    output logic [3:0] serial_peripheral_one_in,
    input wire logic [3:0] serial_peripheral_one_out,
    input wire logic [3:0] serial_peripheral_one_oe,
    // Middle pins: decoder zero / timer group a side
    output logic [3:0] quad_decoder_zero_in,
    input wire logic [3:0] timer_group_a_out,
    input wire logic [3:0] timer_group_a_oe
);
    logic [10:0] port_c_peripheral_enable;
    logic [10:0] port_c_direction;
    logic [10:0] port_c_data;
    logic port_c_peripheral_select;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [10:0] next_out;
    logic [10:0] next_oe;
    logic [21:0] mode_bits;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic pcsm_pkg::pcsm_mode_e pin_mode(input logic per, input logic oe);
        if (!per) begin
            pin_mode = oe ? pcsm_pkg::PCSM_GPIO_OUT : pcsm_pkg::PCSM_GPIO_IN;
        end else begin
            pin_mode = oe ? pcsm_pkg::PCSM_ALT_OUT : pcsm_pkg::PCSM_ALT_IN;
        end
    endfunction : pin_mode

    // Address phase captured; write lands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_c_peripheral_enable <= pcsm_pkg::PER_RESET;
            port_c_direction <= pcsm_pkg::DIR_RESET;
            port_c_data <= pcsm_pkg::DATA_RESET;
            port_c_peripheral_select <= pcsm_pkg::SEL_RESET;
        end else if (wr_pend) begin
            case (wr_addr)
                pcsm_pkg::ADDR_PER: port_c_peripheral_enable <= hwdata[10:0];
                pcsm_pkg::ADDR_DIR: port_c_direction <= hwdata[10:0];
                pcsm_pkg::ADDR_DATA: port_c_data <= hwdata[10:0];
                pcsm_pkg::ADDR_SEL: port_c_peripheral_select <= hwdata[0];
                default: ;
            endcase
        end
    end

    // Pad steering
    always_comb begin
        for (int i = 0; i < pcsm_pkg::PORT_WIDTH; i++) begin
            next_out[i] = port_c_data[i];
            next_oe[i] = port_c_direction[i];
        end
        for (int i = 0; i < pcsm_pkg::LOW_PINS; i++) begin
            if (port_c_peripheral_enable[i]) begin
                if (port_c_peripheral_select == pcsm_pkg::SEL_SERIAL) begin
                    next_out[i] = serial_peripheral_one_out[i];
                    next_oe[i] = serial_peripheral_one_oe[i];
                end else begin
                    next_out[i] = timer_group_b_out[i];
                    next_oe[i] = timer_output_enable[i];
                end
            end
            if (port_c_peripheral_enable[i + 4]) begin
                next_out[i + 4] = timer_group_a_out[i];
                next_oe[i + 4] = timer_group_a_oe[i];
            end
        end
        // Pins 8..10 are dedicated GPIO: enable bit ignored
        for (int i = 8; i < pcsm_pkg::PORT_WIDTH; i++) begin
            next_out[i] = port_c_data[i];
            next_oe[i] = port_c_direction[i];
        end
    end

    // Registered pad drive; inputs gated so the unselected group sees zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out <= 11'h000;
            pad_oe <= 11'h000;
            quad_decoder_one_in <= 4'h0;
            serial_peripheral_one_in <= 4'h0;
            quad_decoder_zero_in <= 4'h0;
        end else begin
            pad_out <= next_out;
            pad_oe <= next_oe;
            quad_decoder_one_in <= pad_in[3:0] & port_c_peripheral_enable[3:0]
                & {4{port_c_peripheral_select == pcsm_pkg::SEL_DECODER}};
            serial_peripheral_one_in <= pad_in[3:0] & port_c_peripheral_enable[3:0]
                & {4{port_c_peripheral_select == pcsm_pkg::SEL_SERIAL}};
            quad_decoder_zero_in <= pad_in[7:4] & port_c_peripheral_enable[7:4];
        end
    end

    always_comb begin
        mode_bits = '0;
        for (int i = 0; i < pcsm_pkg::PORT_WIDTH; i++) begin
            mode_bits[2*i +: 2] = pin_mode(port_c_peripheral_enable[i] && i < 8, next_oe[i]);
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                pcsm_pkg::ADDR_PER: hrdata <= {21'h0, port_c_peripheral_enable};
                pcsm_pkg::ADDR_DIR: hrdata <= {21'h0, port_c_direction};
                pcsm_pkg::ADDR_DATA: hrdata <= {21'h0, port_c_data};
                pcsm_pkg::ADDR_SEL: hrdata <= {31'h0, port_c_peripheral_select};
                pcsm_pkg::ADDR_TOE: hrdata <= {28'h0, timer_output_enable};
                pcsm_pkg::ADDR_PIN: hrdata <= {21'h0, pad_in};
                pcsm_pkg::ADDR_MODE: hrdata <= {10'h0, mode_bits};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    timer_out_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_c_peripheral_enable[0] && !port_c_peripheral_select
        |=> pad_oe[0] == $past(timer_output_enable[0]))
        else $error("timer pin 0 enable mismatch");
    serial_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_c_peripheral_enable[1] && port_c_peripheral_select
        |=> pad_out[1] == $past(serial_peripheral_one_out[1]))
        else $error("serial pin 1 data mismatch");
    gpio_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_c_peripheral_enable[2] |=> pad_oe[2] == $past(port_c_direction[2]))
        else $error("gpio direction mismatch");
    dedicated_gpio_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> pad_out[9] == $past(port_c_data[9]))
        else $error("dedicated pin not gpio");
    exclusive_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (quad_decoder_one_in & serial_peripheral_one_in) == 4'h0)
        else $error("both groups receive pins");
    reset_decoder_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> port_c_peripheral_enable[3:0] == 4'hF
        && port_c_peripheral_select == pcsm_pkg::SEL_DECODER)
        else $error("reset function not decoder");
    select_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_addr == pcsm_pkg::ADDR_SEL |=> port_c_peripheral_select == $past(hwdata[0]))
        else $error("select write lost");
    mid_timer_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_c_peripheral_enable[5] |=> pad_oe[5] == $past(timer_group_a_oe[1]))
        else $error("timer group a pin mismatch");
    serial_sel_c: cover property (@(posedge hclk) disable iff (!hresetn)
        port_c_peripheral_select && port_c_peripheral_enable[0]);
    gpio_out_c: cover property (@(posedge hclk) disable iff (!hresetn)
        !port_c_peripheral_enable[0] && port_c_direction[0]);
    timer_out_c: cover property (@(posedge hclk) disable iff (!hresetn)
        pad_oe[0] && port_c_peripheral_enable[0] && !port_c_peripheral_select);
endmodule : pcsm_mux

/* shared/pcsm_pkg.sv */
package pcsm_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_PER = 8'h00;
    localparam logic [7:0] ADDR_DIR = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_SEL = 8'h0C;
    localparam logic [7:0] ADDR_TOE = 8'h10;
    localparam logic [7:0] ADDR_PIN = 8'h14;
    localparam logic [7:0] ADDR_MODE = 8'h18;
    // Port C geometry
    localparam int PORT_WIDTH = 11;
    localparam int LOW_PINS = 4;
    // Reset values: low and middle pins start as peripheral, dedicated pins as GPIO
    localparam logic [10:0] PER_RESET = 11'h0FF;
    localparam logic [10:0] DIR_RESET = 11'h000;
    localparam logic [10:0] DATA_RESET = 11'h000;
    localparam logic SEL_RESET = 1'b0;
    localparam logic [3:0] TOE_RESET = 4'h0;
    // Per-pin function codes shown in the mode register
    typedef enum logic [1:0] {
        PCSM_GPIO_IN,
        PCSM_GPIO_OUT,
        PCSM_ALT_IN,
        PCSM_ALT_OUT
    } pcsm_mode_e;
    // Select values
    localparam logic SEL_DECODER = 1'b0;
    localparam logic SEL_SERIAL = 1'b1;
endpackage : pcsm_pkg

/* testbench/pcsm_mux_bench.sv */
`timescale 1ns/10ps
module pcsm_mux_bench;
    typedef struct packed {
        logic [10:0] per, dir, data;
        logic sel;
        logic [3:0] toe;
        logic [10:0] oe, out;
        logic [3:0] quad_decoder_one, spi, quad_decoder_zero;
    } pcsm_row_s;
    pcsm_row_s rows [6] = '{
        '{11'h000, 11'h000, 11'h7FF, 1'b0, 4'hF, 11'h000, 11'h000, 4'h0, 4'h0, 4'h0},
        '{11'h000, 11'h7FF, 11'h2C5, 1'b0, 4'h0, 11'h7FF, 11'h2C5, 4'h0, 4'h0, 4'h0},
        '{11'h0FF, 11'h000, 11'h000, 1'b0, 4'h0, 11'h060, 11'h000, 4'h3, 4'h0, 4'hA},
        '{11'h0FF, 11'h000, 11'h000, 1'b0, 4'h3, 11'h063, 11'h001, 4'h3, 4'h0, 4'hA},
        '{11'h0FF, 11'h700, 11'h500, 1'b1, 4'hF, 11'h76C, 11'h508, 4'h0, 4'h3, 4'hA},
        '{11'h0F0, 11'h00F, 11'h00A, 1'b1, 4'hF, 11'h06F, 11'h00A, 4'h0, 4'h0, 4'hA}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [1:0] htrans = 2'h0;
    logic [3:0] toe = 4'h0;
    logic [3:0] ta_oe = 4'h6;
    logic [3:0] tb_out = 4'h5;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [10:0] pad_out, pad_oe;
    logic [3:0] quad_decoder_one, spi, quad_decoder_zero;
    int n_fail = 0;
    int check_count = 0;
    // The one slave's hreadyout is the bus hready
    pcsm_mux i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(11'h5A3),
        .pad_out(pad_out), .pad_oe(pad_oe), .quad_decoder_one_in(quad_decoder_one),
        .timer_group_b_out(tb_out), .timer_output_enable(toe), .serial_peripheral_one_in(spi),
        .serial_peripheral_one_out(4'hA), .serial_peripheral_one_oe(4'hC),
        .quad_decoder_zero_in(quad_decoder_zero), .timer_group_a_out(4'h9), .timer_group_a_oe(ta_oe));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg
    task chk_pin(input string name, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_pin
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        #1;
        chk_pin("pad_oe in reset", 11'h000, pad_oe);
        @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset
    task results;
        $display("Checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    initial begin
        #100us;
        n_fail++;
        results();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            @(posedge hclk);
            toe <= rows[i].toe;
            bus(1'b1, pcsm_pkg::ADDR_PER, {21'h00_0000, rows[i].per});
            bus(1'b1, pcsm_pkg::ADDR_DIR, {21'h00_0000, rows[i].dir});
            bus(1'b1, pcsm_pkg::ADDR_DATA, {21'h00_0000, rows[i].data});
            bus(1'b1, pcsm_pkg::ADDR_SEL, {31'h0000_0000, rows[i].sel});
            bus(1'b0, pcsm_pkg::ADDR_PER, 32'h0000_0000);
            chk_reg("enable", {21'h00_0000, rows[i].per}, rd);
            // Pads lag by one edge; a second edge keeps us clear of it
            repeat (2) @(posedge hclk);
            #1;
            chk_pin("pad_oe", rows[i].oe, pad_oe);
            chk_pin("pad_out", rows[i].out, pad_out & rows[i].oe);
            chk_pin("dec one in", {7'h00, rows[i].quad_decoder_one}, {7'h00, quad_decoder_one});
            chk_pin("serial in", {7'h00, rows[i].spi}, {7'h00, spi});
            chk_pin("dec zero in", {7'h00, rows[i].quad_decoder_zero}, {7'h00, quad_decoder_zero});
            $display("Test row %0d done", i);
        end
        bus(1'b1, pcsm_pkg::ADDR_PER, 32'hFFFF_FFFF);
        bus(1'b0, pcsm_pkg::ADDR_PER, 32'h0000_0000);
        chk_reg("enable width", 32'h0000_07FF, rd);
        bus(1'b1, pcsm_pkg::ADDR_TOE, 32'h0000_0000);
        bus(1'b0, pcsm_pkg::ADDR_TOE, 32'h0000_0000);
        chk_reg("read-only toe", 32'h0000_000F, rd);
        bus(1'b1, 8'h1C, 32'h0000_0055);
        bus(1'b0, 8'h1C, 32'h0000_0000);
        chk_reg("unmapped", 32'h0000_0000, rd);
        bus(1'b0, pcsm_pkg::ADDR_PIN, 32'h0000_0000);
        chk_reg("pad input", 32'h0000_05A3, rd);
        $display("Test register edges done");
        toe <= 4'h0;
        ta_oe <= 4'h0;
        do_reset();
        bus(1'b0, pcsm_pkg::ADDR_PER, 32'h0000_0000);
        chk_reg("enable reset", 32'h0000_00FF, rd);
        bus(1'b0, pcsm_pkg::ADDR_SEL, 32'h0000_0000);
        chk_reg("select reset", 32'h0000_0000, rd);
        bus(1'b0, pcsm_pkg::ADDR_MODE, 32'h0000_0000);
        chk_reg("mode reset", 32'h0000_AAAA, rd);
        #1;
        chk_pin("dec one reset", 11'h003, {7'h00, quad_decoder_one});
        chk_pin("pad_oe reset", 11'h000, pad_oe);
        $display("Test second reset done");
        // Timer drive on the low pins, with a new timer value to catch a stuck path
        @(posedge hclk);
        toe <= 4'hF;
        tb_out <= 4'hA;
        repeat (2) @(posedge hclk);
        #1;
        chk_pin("timer drive oe", 11'h00F, pad_oe);
        chk_pin("timer drive out", 11'h00A, pad_out & 11'h00F);
        chk_reg("bus response", 32'h0000_0000, {31'h0000_0000, hresp});
        $display("Test timer drive done");
        results();
    end
endmodule : pcsm_mux_bench
